// ===== dasio_ports.sv
/*
 * Two analog-shared 8-bit ports and one plain 8-bit port with open-drain select, behind an APB slave.
 * Assumes pins resolved outside from OUT/OE pairs, a converter consuming channel and start, one 50 MHz clock.
 */
// The APB slave port was decided locally.
// Behaviour
// - Reset clears shared-port direction and latches, sets input disable, inputs read low.
// - Shared-port direction 1 drives the pin from its latch (bit 7 from latch AND debug input) regardless of disable.
// - Converted channel comes from the channel select field, not from pin setup.
// - Shared-port bits whose latch holds 0 always read back 0.
// - Reads return pins for inputs whose latch holds 1; a write stores all eight latch bits.
// - Plain port has direction and latch registers, both cleared to 0 at reset.
// - Plain port has a drain select register reset to 0, tri-state style.
// - Plain-port read-modify-write view returns latch for drain bits, else pins.
// - Drain select 0 means tri-state drive, 1 means open-drain drive.
`timescale 1ns/100ps
`include "dasio_defs.svh"

module dasio_ports
	import dasio_pkg::*;
(
	input  wire logic        CLOCK_I,
	input  wire logic        RST_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [15:0] PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	input  wire logic [7:0]  A_PIN_I,
	output logic      [7:0]  A_OUT_O,
	output logic      [7:0]  A_OE_O,
	output logic      [7:0]  A_ANALOG_O,
	input  wire logic [7:0]  B_PIN_I,
	output logic      [7:0]  B_OUT_O,
	output logic      [7:0]  B_OE_O,
	output logic      [7:0]  B_ANALOG_O,
	input  wire logic [7:0]  C_PIN_I,
	output logic      [7:0]  C_OUT_O,
	output logic      [7:0]  C_OE_O,
	input  wire logic        DEBUG_ONE_I,
	input  wire logic        DEBUG_TWO_I,
	output logic      [3:0]  CONV_CHANNEL_O,
	output logic             CONV_START_O
);

	dasio_state_s                  st_reg;
	dasio_state_s                  st_next;
	logic         [23:0]           pin_sync;
	dasio_byte_t                   a_pin;
	dasio_byte_t                   b_pin;
	dasio_byte_t                   c_pin;
	logic                          setup;
	logic                          access;
	logic                          wr;
	logic                          hit;
	logic         [`DASIO_IDX_W-1:0] word;
	dasio_byte_t                   rd;
	dasio_byte_t                   a_rd;
	dasio_byte_t                   b_rd;
	dasio_byte_t                   c_rmw;
	dasio_byte_t                   a_drv;
	dasio_byte_t                   b_drv;
	dasio_byte_t                   c_drv;

	dasio_sync #(
		.W (24)
	) u_sync (
		.clk_i (CLOCK_I),
		.rst_i (RST_I),
		.d_i   ({C_PIN_I, B_PIN_I, A_PIN_I}),
		.q_o   (pin_sync)
	);

	assign a_pin = pin_sync[7:0];
	assign b_pin = pin_sync[15:8];
	assign c_pin = pin_sync[23:16];

	// Input bits with latch 0 read low; output bits read their latch.
	assign a_rd  = st_reg.a_lat & (st_reg.a_dir | a_pin);
	assign b_rd  = st_reg.b_lat & (st_reg.b_dir | b_pin);
	assign c_rmw = (st_reg.c_od & st_reg.c_lat) | (~st_reg.c_od & c_pin);

	always_comb begin
		st_next       = st_reg;
		st_next.start = 1'b0;
		setup         = PSEL_I & ~PENABLE_I;
		access        = PSEL_I & PENABLE_I;
		wr            = access & PWRITE_I;
		word          = PADDR_I[15:2];
		hit           = 1'b1;
		rd            = `DASIO_PORT_RST;
		unique case (word)
			`DASIO_A_LAT_IDX: rd = a_rd;
			`DASIO_B_LAT_IDX: rd = b_rd;
			`DASIO_A_DIR_IDX: rd = st_reg.a_dir;
			`DASIO_B_DIR_IDX: rd = st_reg.b_dir;
			`DASIO_C_LAT_IDX: rd = c_pin;
			`DASIO_C_RMW_IDX: rd = c_rmw;
			`DASIO_C_DIR_IDX: rd = st_reg.c_dir;
			`DASIO_C_OD_IDX:  rd = st_reg.c_od;
			`DASIO_CONV_IDX: begin
				rd[`DASIO_CHAN_MSB:`DASIO_CHAN_LSB] = st_reg.chan;
				rd[`DASIO_DIS_BIT]                  = st_reg.ain_dis;
			end
			default: hit = 1'b0;
		endcase
		if (PADDR_I[1:0] != 2'b00) begin
			hit = 1'b0;
		end
		// Read data and the error flag are captured in the setup cycle.
		if (setup) begin
			st_next.rdata  = `DASIO_RDATA_RST;
			st_next.slverr = ~hit;
			if (!PWRITE_I && hit) begin
				st_next.rdata[7:0] = rd;
			end
		end
		// A port register write stores the whole byte, whatever was read before.
		if (wr && hit) begin
			unique case (word)
				`DASIO_A_LAT_IDX: st_next.a_lat = PWDATA_I[7:0];
				`DASIO_B_LAT_IDX: st_next.b_lat = PWDATA_I[7:0];
				`DASIO_A_DIR_IDX: st_next.a_dir = PWDATA_I[7:0];
				`DASIO_B_DIR_IDX: st_next.b_dir = PWDATA_I[7:0];
				`DASIO_C_LAT_IDX: st_next.c_lat = PWDATA_I[7:0];
				`DASIO_C_RMW_IDX: st_next.c_lat = PWDATA_I[7:0];
				`DASIO_C_DIR_IDX: st_next.c_dir = PWDATA_I[7:0];
				`DASIO_C_OD_IDX:  st_next.c_od  = PWDATA_I[7:0];
				`DASIO_CONV_IDX: begin
					st_next.ain_dis = PWDATA_I[`DASIO_DIS_BIT];
					st_next.chan    = PWDATA_I[`DASIO_CHAN_MSB:`DASIO_CHAN_LSB];
					st_next.start   = ~PWDATA_I[`DASIO_DIS_BIT];
				end
				default: st_next.start = 1'b0;
			endcase
		end
		// The debug signal is gated by the bit 7 latch.
		a_drv                 = st_next.a_lat;
		b_drv                 = st_next.b_lat;
		a_drv[`DASIO_DBG_BIT] = st_next.a_lat[`DASIO_DBG_BIT] & DEBUG_ONE_I;
		b_drv[`DASIO_DBG_BIT] = st_next.b_lat[`DASIO_DBG_BIT] & DEBUG_TWO_I;
		st_next.a_out         = a_drv;
		st_next.a_oe          = st_next.a_dir;
		st_next.b_out         = b_drv;
		st_next.b_oe          = st_next.b_dir;
		st_next.a_ana         = ~st_next.a_dir & ~st_next.a_lat & {8{~st_next.ain_dis}};
		st_next.b_ana         = ~st_next.b_dir & ~st_next.b_lat & {8{~st_next.ain_dis}};
		// Open-drain bits drive only a low level and release on latch 1.
		c_drv         = st_next.c_lat & ~st_next.c_od;
		st_next.c_out = c_drv;
		st_next.c_oe  = st_next.c_dir & (~st_next.c_od | ~st_next.c_lat);
	end

	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			st_reg         <= '0;
			st_reg.ain_dis <= `DASIO_DIS_RST;
			st_reg.chan    <= `DASIO_CHAN_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign PRDATA_O       = st_reg.rdata;
	assign PSLVERR_O      = st_reg.slverr & PSEL_I & PENABLE_I;
	assign PREADY_O       = 1'b1;
	assign A_OUT_O        = st_reg.a_out;
	assign A_OE_O         = st_reg.a_oe;
	assign A_ANALOG_O     = st_reg.a_ana;
	assign B_OUT_O        = st_reg.b_out;
	assign B_OE_O         = st_reg.b_oe;
	assign B_ANALOG_O     = st_reg.b_ana;
	assign C_OUT_O        = st_reg.c_out;
	assign C_OE_O         = st_reg.c_oe;
	assign CONV_CHANNEL_O = st_reg.chan;
	assign CONV_START_O   = st_reg.start;

	default clocking cb @(posedge CLOCK_I);
	endclocking

	default disable iff (RST_I);

	a_reset_clears_ports: assert property (
		$fell(RST_I) |-> A_OE_O == 8'h00 && B_OE_O == 8'h00 && st_reg.a_lat == 8'h00 && st_reg.ain_dis
	) else $error("shared ports not cleared by reset");

	a_output_mode_drive: assert property (
		wr && hit && word == `DASIO_A_DIR_IDX && PWDATA_I[0] |=> A_OE_O[0] && A_OUT_O[0] == st_reg.a_lat[0]
	) else $error("direction 1 did not drive the shared pin");

	a_start_one_pulse: assert property (
		wr && hit && word == `DASIO_CONV_IDX && !PWDATA_I[0] |=> CONV_START_O ##1 !CONV_START_O
	) else $error("conversion start is not a single pulse");

	a_channel_follows_write: assert property (
		wr && hit && word == `DASIO_CONV_IDX |=> CONV_CHANNEL_O == $past(PWDATA_I[7:4])
	) else $error("channel select did not follow its write");

	a_zero_latch_reads: assert property (
		setup && !PWRITE_I && word == `DASIO_B_LAT_IDX && PADDR_I[1:0] == 2'b00
		|=> (PRDATA_O[7:0] & ~$past(st_reg.b_lat)) == 8'h00
	) else $error("bit with latch 0 did not read 0");

	a_latch_whole_byte: assert property (
		wr && hit && word == `DASIO_A_LAT_IDX |=> st_reg.a_lat == $past(PWDATA_I[7:0])
	) else $error("latch write did not store all eight bits");

	a_debug_gated: assert property (
		!st_reg.a_lat[7] && !$past(st_reg.a_lat[7]) |-> !A_OUT_O[7]
	) else $error("debug output reached pin with latch 0");

	a_plain_reset: assert property (
		$fell(RST_I) |-> C_OE_O == 8'h00 && st_reg.c_od == 8'h00 && st_reg.c_lat == 8'h00
	) else $error("plain port not cleared by reset");

	a_rmw_view: assert property (
		setup && !PWRITE_I && word == `DASIO_C_RMW_IDX && PADDR_I[1:0] == 2'b00
		|=> PRDATA_O[7:0] == (($past(st_reg.c_od) & $past(st_reg.c_lat)) | (~$past(st_reg.c_od) & $past(c_pin)))
	) else $error("read-modify-write view returned wrong data");

	a_drain_low_only: assert property (
		st_reg.c_od[0] |-> !C_OUT_O[0] && (C_OE_O[0] == (st_reg.c_dir[0] && !st_reg.c_lat[0]))
	) else $error("open-drain bit drove high or released on latch 0");

	a_plain_dir_drive: assert property (
		wr && hit && word == `DASIO_C_DIR_IDX && !PWDATA_I[7] |=> !C_OE_O[7] [*2]
	) else $error("direction 0 did not release the plain pin");

	a_tristate_drive: assert property (
		!st_reg.c_od[1] && st_reg.c_dir[1] |-> C_OE_O[1] && C_OUT_O[1] == st_reg.c_lat[1]
	) else $error("tri-state bit not driven from latch");

	a_reset_pins_low: assert property (
		$fell(RST_I)
		|-> A_OUT_O == 8'h00 && B_OUT_O == 8'h00 && A_ANALOG_O == 8'h00 && B_ANALOG_O == 8'h00
	) else $error("shared pins not quiet after reset");

	a_reset_conv_idle: assert property (
		$fell(RST_I)
		|-> !CONV_START_O && CONV_CHANNEL_O == 4'h0 && PRDATA_O == 32'h0000_0000
	) else $error("converter controls not idle after reset");

	a_shared_a_drive: assert property (
		st_reg.a_dir[2]
		|-> A_OE_O[2] && A_OUT_O[2] == st_reg.a_lat[2] && !A_ANALOG_O[2]
	) else $error("port A output bit not driven from its latch");

	a_shared_b_drive: assert property (
		st_reg.b_dir[0]
		|-> B_OE_O[0] && B_OUT_O[0] == st_reg.b_lat[0] && !B_ANALOG_O[0]
	) else $error("port B output bit not driven from its latch");

	a_analog_mode_decode: assert property (
		A_ANALOG_O[3]
		|-> !A_OE_O[3] && !st_reg.a_lat[3] && !st_reg.ain_dis
	) else $error("analog mode flagged without its setup");

	a_start_needs_write: assert property (
		CONV_START_O
		|-> $past(wr) && $past(hit) && $past(word) == `DASIO_CONV_IDX && !$past(PWDATA_I[`DASIO_DIS_BIT])
	) else $error("conversion started without a control write");

	a_start_single: assert property (
		CONV_START_O
		|=> !CONV_START_O
	) else $error("conversion start held longer than one cycle");

	a_channel_holds: assert property (
		!$past(RST_I) && !($past(wr) && $past(word) == `DASIO_CONV_IDX)
		|-> $stable(CONV_CHANNEL_O)
	) else $error("channel select changed without a write");

	a_zero_latch_a: assert property (
		setup && !PWRITE_I && word == `DASIO_A_LAT_IDX && PADDR_I[1:0] == 2'b00
		|=> (PRDATA_O[7:0] & ~$past(st_reg.a_lat)) == 8'h00
	) else $error("port A bit with latch 0 did not read 0");

	a_input_reads_pin: assert property (
		setup && !PWRITE_I && word == `DASIO_A_LAT_IDX && PADDR_I[1:0] == 2'b00
		|=> (PRDATA_O[7:0] & $past(st_reg.a_lat) & ~$past(st_reg.a_dir))
			== ($past(a_pin) & $past(st_reg.a_lat) & ~$past(st_reg.a_dir))
	) else $error("input bit did not read its pin");

	a_output_reads_latch: assert property (
		setup && !PWRITE_I && word == `DASIO_B_LAT_IDX && PADDR_I[1:0] == 2'b00
		|=> (PRDATA_O[7:0] & $past(st_reg.b_dir)) == ($past(st_reg.b_lat) & $past(st_reg.b_dir))
	) else $error("output bit did not read its latch");

	a_debug_two_gated: assert property (
		!st_reg.b_lat[7]
		|-> !B_OUT_O[7]
	) else $error("second debug output reached pin with latch 0");

	a_debug_one_passes: assert property (
		st_reg.a_lat[7] && $past(DEBUG_ONE_I)
		|-> A_OUT_O[7]
	) else $error("first debug output blocked with latch 1");

	a_debug_two_passes: assert property (
		st_reg.b_lat[7] && $past(DEBUG_TWO_I)
		|-> B_OUT_O[7]
	) else $error("second debug output blocked with latch 1");

	a_plain_latch_store: assert property (
		wr && hit && word == `DASIO_C_LAT_IDX
		|=> st_reg.c_lat == $past(PWDATA_I[7:0])
	) else $error("plain latch write not stored");

	a_drain_select_store: assert property (
		wr && hit && word == `DASIO_C_OD_IDX
		|=> st_reg.c_od == $past(PWDATA_I[7:0])
	) else $error("drain select write not stored");

	a_plain_pin_read: assert property (
		setup && !PWRITE_I && word == `DASIO_C_LAT_IDX && PADDR_I[1:0] == 2'b00
		|=> PRDATA_O[7:0] == $past(c_pin)
	) else $error("plain port read did not return the pins");

	a_plain_dir_release: assert property (
		!st_reg.c_dir[5]
		|-> !C_OE_O[5]
	) else $error("plain pin driven with direction 0");

	a_drain_release: assert property (
		st_reg.c_od[2] && st_reg.c_lat[2]
		|-> !C_OE_O[2]
	) else $error("open-drain bit with latch 1 still driven");

	a_drain_pull_low: assert property (
		st_reg.c_od[1] && !st_reg.c_lat[1] && st_reg.c_dir[1]
		|-> C_OE_O[1] && !C_OUT_O[1]
	) else $error("open-drain bit with latch 0 not pulled low");

endmodule

// ===== dasio_defs.svh
/*
 * Register indices, field positions, widths and reset values of the shared I/O ports.
 * Assumes it is included by bare name before any package import; it defines macros only.
 */
`ifndef DASIO_DEFS_SVH
`define DASIO_DEFS_SVH

`define DASIO_PORT_W     8
`define DASIO_CHAN_W     4
`define DASIO_IDX_W      14
`define DASIO_A_LAT_IDX  14'h0006
`define DASIO_B_LAT_IDX  14'h0007
`define DASIO_A_DIR_IDX  14'h1F8C
`define DASIO_B_DIR_IDX  14'h1F8D
`define DASIO_C_LAT_IDX  14'h0008
`define DASIO_C_DIR_IDX  14'h1F8E
`define DASIO_C_OD_IDX   14'h1F86
`define DASIO_C_RMW_IDX  14'h0108
`define DASIO_CONV_IDX   14'h1FC0
`define DASIO_PORT_RST   8'h00
`define DASIO_DIS_RST    1'b1
`define DASIO_CHAN_RST   4'h0
`define DASIO_DIS_BIT    0
`define DASIO_CHAN_LSB   4
`define DASIO_CHAN_MSB   7
`define DASIO_DBG_BIT    7
`define DASIO_RDATA_RST  32'h0000_0000

`endif

// ===== dasio_pkg.sv
/*
 * Types shared by the shared I/O port block.
 * Assumes dasio_defs.svh is available on the include path.
 */
`include "dasio_defs.svh"

package dasio_pkg;

	typedef logic [`DASIO_PORT_W-1:0] dasio_byte_t;

	typedef struct packed {
		dasio_byte_t              a_lat;
		dasio_byte_t              a_dir;
		dasio_byte_t              b_lat;
		dasio_byte_t              b_dir;
		dasio_byte_t              c_lat;
		dasio_byte_t              c_dir;
		dasio_byte_t              c_od;
		logic                     ain_dis;
		logic [`DASIO_CHAN_W-1:0] chan;
		logic                     start;
		dasio_byte_t              a_out;
		dasio_byte_t              a_oe;
		dasio_byte_t              a_ana;
		dasio_byte_t              b_out;
		dasio_byte_t              b_oe;
		dasio_byte_t              b_ana;
		dasio_byte_t              c_out;
		dasio_byte_t              c_oe;
		logic [31:0]              rdata;
		logic                     slverr;
	} dasio_state_s;

endpackage

// ===== dasio_sync.sv
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes asynchronous pin levels on its input and a synchronous active-high reset.
 */
`timescale 1ns/100ps

module dasio_sync #(
	parameter int W = 8
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} dasio_sync_s;

	dasio_sync_s sync_reg;
	dasio_sync_s sync_next;

	if (W < 1) begin : g_bad_width
		$error("dasio_sync: width must be at least one");
	end

	// A bit follows the pin only once the second and third stages agree.
	always_comb begin
		sync_next    = sync_reg;
		sync_next.s1 = d_i;
		sync_next.s2 = sync_reg.s1;
		sync_next.s3 = sync_reg.s2;
		sync_next.q  = (sync_reg.s2 & ~(sync_reg.s2 ^ sync_reg.s3)) | (sync_reg.q & (sync_reg.s2 ^ sync_reg.s3));
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_reg <= '0;
		end else begin
			sync_reg <= sync_next;
		end
	end

	assign q_o = sync_reg.q;

endmodule

// ===== dasio_far.sv
/*
 * Far-side model: the pads of the three ports and the converter's start and channel intake.
 * Assumes OUT/OE pairs from the port block and external pin levels supplied by the bench.
 */
`timescale 1ns/100ps

module dasio_far
	import dasio_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic [23:0] out_i,
	input  wire logic [23:0] oe_i,
	input  wire logic [23:0] ext_i,
	output logic      [23:0] pin_o,
	input  wire logic        start_i,
	input  wire logic [3:0]  chan_i,
	output logic      [3:0]  chan_o,
	output int               starts_o
);
	// A driven bit shows the block's value, a released bit shows the outside level.
	assign pin_o = (oe_i & out_i) | (~oe_i & ext_i);
	// Every start pulse launches one conversion of the channel selected at that moment.
	always @(posedge clk_i) begin
		if (start_i === 1'h1) begin
			starts_o <= starts_o + 1;
			chan_o   <= chan_i;
		end
	end
endmodule

// ===== dasio_ports_tb.sv
/*
 * Self-checking bench for the shared I/O port block, driving APB and the outside pin levels.
 * Assumes dasio_pkg, dasio_defs.svh and the far-side model are compiled first.
 */
`timescale 1ns/100ps
`include "dasio_defs.svh"
`define CHK(a, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; $display("ERROR %s expected %h seen %h", a, e, g); end end

module dasio_ports_tb;
	import dasio_pkg::*;
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  a_out, a_oe, a_ana, b_out, b_oe, b_ana, c_out, c_oe;
	logic        dbg1 = 1'h0;
	logic        dbg2 = 1'h0;
	logic [3:0]  chan, conv_chan;
	logic        start;
	logic [23:0] ext = 24'hFF_FFFF;
	logic [23:0] pins;
	int          starts, mismatches = 0, samples_checked = 0;

	always #10 clk = ~clk;

	dasio_ports dasio_ports_inst (.CLOCK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .A_PIN_I(pins[7:0]), .A_OUT_O(a_out), .A_OE_O(a_oe), .A_ANALOG_O(a_ana),
		.B_PIN_I(pins[15:8]), .B_OUT_O(b_out), .B_OE_O(b_oe), .B_ANALOG_O(b_ana), .C_PIN_I(pins[23:16]),
		.C_OUT_O(c_out), .C_OE_O(c_oe), .DEBUG_ONE_I(dbg1), .DEBUG_TWO_I(dbg2), .CONV_CHANNEL_O(chan),
		.CONV_START_O(start));
	dasio_far dasio_far_inst (.clk_i(clk), .out_i({c_out, b_out, a_out}), .oe_i({c_oe, b_oe, a_oe}),
		.ext_i(ext), .pin_o(pins), .start_i(start), .chan_i(chan), .chan_o(conv_chan), .starts_o(starts));

	task automatic apb(input logic w, input logic [13:0] idx, input logic [7:0] wd, output logic [31:0] r,
		output logic e);
		@(posedge clk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= w;
		paddr   <= {idx, 2'h0};
		pwdata  <= {24'h00_0000, wd};
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
		end while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic wr(input logic [13:0] idx, input logic [7:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'h1, idx, d, r, e);
	endtask

	task automatic rd(input string a, input logic [13:0] idx, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic        e;
		apb(1'h0, idx, 8'h00, r, e);
		`CHK(a, x, r)
		`CHK("pslverr", xe, e)
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic t_reset();
		`CHK("oe", 24'h00_0000, {c_oe, b_oe, a_oe})
		`CHK("ana", 16'h0000, {b_ana, a_ana})
		rd("a_lat", `DASIO_A_LAT_IDX, 32'h0000_0000, 1'h0);
		rd("b_lat", `DASIO_B_LAT_IDX, 32'h0000_0000, 1'h0);
		rd("a_dir", `DASIO_A_DIR_IDX, 32'h0000_0000, 1'h0);
		rd("b_dir", `DASIO_B_DIR_IDX, 32'h0000_0000, 1'h0);
		rd("c_dir", `DASIO_C_DIR_IDX, 32'h0000_0000, 1'h0);
		rd("c_od", `DASIO_C_OD_IDX, 32'h0000_0000, 1'h0);
		rd("conv", `DASIO_CONV_IDX, 32'h0000_0001, 1'h0);
		rd("unmapped", 14'h0001, 32'h0000_0000, 1'h1);
		$display("test reset done");
	endtask

	task automatic t_input();
		@(posedge clk);
		ext <= 24'h00_3CA5;
		wr(`DASIO_A_LAT_IDX, 8'hFF);
		wr(`DASIO_B_LAT_IDX, 8'hFF);
		settle(6);
		rd("a_in", `DASIO_A_LAT_IDX, 32'h0000_00A5, 1'h0);
		rd("b_in", `DASIO_B_LAT_IDX, 32'h0000_003C, 1'h0);
		wr(`DASIO_A_LAT_IDX, 8'h0F);
		rd("a_half", `DASIO_A_LAT_IDX, 32'h0000_0005, 1'h0);
		$display("test input done");
	endtask

	task automatic t_output();
		wr(`DASIO_A_LAT_IDX, 8'h35);
		wr(`DASIO_A_DIR_IDX, 8'hFF);
		settle(1);
		`CHK("a_oe", 8'hFF, a_oe)
		`CHK("a_out", 8'h35, a_out)
		rd("a_drv", `DASIO_A_LAT_IDX, 32'h0000_0035, 1'h0);
		wr(`DASIO_A_LAT_IDX, 8'h80);
		wr(`DASIO_A_DIR_IDX, 8'h80);
		wr(`DASIO_B_LAT_IDX, 8'h80);
		wr(`DASIO_B_DIR_IDX, 8'h80);
		dbg1 <= 1'h1;
		settle(3);
		`CHK("dbg", 16'h0080, {b_out, a_out})
		@(posedge clk);
		dbg2 <= 1'h1;
		wr(`DASIO_A_LAT_IDX, 8'h00);
		settle(3);
		`CHK("dbg_gate", 16'h8000, {b_out, a_out})
		$display("test output done");
	endtask

	task automatic t_analog();
		int s0;
		wr(`DASIO_A_DIR_IDX, 8'h00);
		wr(`DASIO_B_DIR_IDX, 8'h00);
		wr(`DASIO_B_LAT_IDX, 8'hF0);
		@(posedge clk);
		ext <= 24'h00_FFFF;
		s0 = starts;
		wr(`DASIO_CONV_IDX, 8'h90);
		settle(2);
		`CHK("starts", s0 + 1, starts)
		`CHK("chan", 4'h9, conv_chan)
		`CHK("ana", 16'h0FFF, {b_ana, a_ana})
		settle(4);
		rd("a_ana", `DASIO_A_LAT_IDX, 32'h0000_0000, 1'h0);
		rd("b_ana", `DASIO_B_LAT_IDX, 32'h0000_00F0, 1'h0);
		wr(`DASIO_CONV_IDX, 8'h30);
		settle(2);
		`CHK("restart", s0 + 2, starts)
		`CHK("chan2", 4'h3, conv_chan)
		rd("conv_rb", `DASIO_CONV_IDX, 32'h0000_0030, 1'h0);
		wr(`DASIO_CONV_IDX, 8'h01);
		settle(2);
		`CHK("no_start", s0 + 2, starts)
		`CHK("ana_off", 16'h0000, {b_ana, a_ana})
		$display("test analog done");
	endtask

	task automatic t_plain();
		@(posedge clk);
		ext <= 24'h00_FFFF;
		wr(`DASIO_C_DIR_IDX, 8'hFF);
		wr(`DASIO_C_LAT_IDX, 8'hA5);
		wr(`DASIO_C_OD_IDX, 8'h0F);
		settle(1);
		`CHK("c_oe", 8'hFA, c_oe)
		`CHK("c_out", 8'hA0, c_out)
		settle(5);
		rd("c_rmw", `DASIO_C_RMW_IDX, 32'h0000_00A5, 1'h0);
		rd("c_pin", `DASIO_C_LAT_IDX, 32'h0000_00A0, 1'h0);
		wr(`DASIO_C_DIR_IDX, 8'h0F);
		settle(1);
		`CHK("c_rel", 8'h0A, c_oe)
		wr(`DASIO_C_RMW_IDX, 8'h3C);
		settle(1);
		`CHK("c_rmw_wr", 16'h0330, {c_oe, c_out})
		rd("c_od", `DASIO_C_OD_IDX, 32'h0000_000F, 1'h0);
		$display("test plain done");
	endtask

	task automatic summarize();
		$display("compared %0d mismatched %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		settle(1);
		t_reset();
		t_input();
		t_output();
		t_analog();
		t_plain();
		summarize();
	end

	initial begin
		repeat (5000) @(posedge clk);
		mismatches++;
		summarize();
	end
endmodule
